/* File: core/tmr_defs.svh */
// Address map, control field positions and reset values of the timer views.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_ADDR_W 5
`define TMR_DATA_W 64
`define TMR_CDV_W 32
`define TMR_CH_SEL_W 2

// Global registers.
`define TMR_ADDR_PHYS_COUNT 5'h00
`define TMR_ADDR_VIRT_COUNT 5'h01
`define TMR_ADDR_VIRT_OFFSET 5'h02

// Channel registers sit at 0x10 + 4 * channel + kind.
`define TMR_CH_SPACE_BIT 4
`define TMR_CH_IDX_HI 3
`define TMR_CH_IDX_LO 2
`define TMR_KIND_HI 1
`define TMR_KIND_LO 0
`define TMR_KIND_W 2
`define TMR_KIND_COMPARE 2'h0
`define TMR_KIND_COUNTDOWN 2'h1
`define TMR_KIND_CONTROL 2'h2

// Control register fields.
`define TMR_CTRL_ENABLE 0
`define TMR_CTRL_IMASK 1
`define TMR_CTRL_STATUS 2
`define TMR_CTRL_W 2

// Reset values.
`define TMR_RST_THRESHOLD 64'h0000_0000_0000_0000
`define TMR_RST_OFFSET 64'h0000_0000_0000_0000
`define TMR_RST_CTRL 2'h0

`endif

/* File: core/tmr_pkg.sv */
// Types shared by the timer views: access request and response carriers.
// Assumes tmr_defs.svh supplies the widths.
`include "tmr_defs.svh"

package tmr_pkg;

   typedef struct packed {
      logic write;
      logic [`TMR_ADDR_W-1:0] addr;
      logic [`TMR_DATA_W-1:0] wdata;
   } tmr_req_t;

   typedef struct packed {
      logic err;
      logic [`TMR_DATA_W-1:0] rdata;
   } tmr_rsp_t;

endpackage

/* File: core/tmr_count_track.sv */
// Holds the virtual offset and derives physical and virtual counts.
// Assumes sys_count comes from a free-running counter on the same clock.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_count_track (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`TMR_DATA_W-1:0] sys_count,
   input wire logic offset_wr,
   input wire logic [`TMR_DATA_W-1:0] offset_wdata,
   output logic [`TMR_DATA_W-1:0] phys_count,
   output logic [`TMR_DATA_W-1:0] virt_count,
   output logic [`TMR_DATA_W-1:0] offset_q
);

   logic [`TMR_DATA_W-1:0] offset_d;

   assign offset_d = offset_wr ? offset_wdata : offset_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         offset_q <= `TMR_RST_OFFSET;
      end else begin
         offset_q <= offset_d;
      end
   end

   // The difference wraps naturally in 64 bits.
   assign phys_count = sys_count;
   assign virt_count = sys_count - offset_q;

endmodule

/* File: core/tmr_channel.sv */
// One timer channel: one stored threshold behind both views, plus control.
// Assumes adj_count is already the count less this channel's offset.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_channel (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`TMR_DATA_W-1:0] adj_count,
   input wire logic wr_compare,
   input wire logic wr_countdown,
   input wire logic wr_ctrl,
   input wire logic [`TMR_DATA_W-1:0] wdata,
   output logic [`TMR_DATA_W-1:0] threshold_q,
   output logic [`TMR_CTRL_W-1:0] ctrl_q,
   output logic [`TMR_CDV_W-1:0] countdown_value,
   output logic condition_reached,
   output logic irq_level
);

   logic [`TMR_DATA_W-1:0] threshold_d;
   logic [`TMR_DATA_W-1:0] cdv_sext;
   logic [`TMR_DATA_W-1:0] remaining;
   logic [`TMR_CTRL_W-1:0] ctrl_d;

   assign cdv_sext = {{(`TMR_DATA_W-`TMR_CDV_W){wdata[`TMR_CDV_W-1]}}, wdata[`TMR_CDV_W-1:0]};

   // Both views land in the same register.
   assign threshold_d = wr_compare ? wdata :
                        wr_countdown ? adj_count + cdv_sext :
                        threshold_q;

   // Only the two allocated bits are kept; status and upper bits are ignored.
   assign ctrl_d = wr_ctrl ? wdata[`TMR_CTRL_W-1:0] : ctrl_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         threshold_q <= `TMR_RST_THRESHOLD;
         ctrl_q <= `TMR_RST_CTRL;
      end else begin
         threshold_q <= threshold_d;
         ctrl_q <= ctrl_d;
      end
   end

   // Countdown is derived, never stored; past the match it goes negative.
   assign remaining = threshold_q - adj_count;
   assign countdown_value = remaining[`TMR_CDV_W-1:0];

   // Unsigned compare, so a near all-ones threshold may never be met.
   assign condition_reached = ctrl_q[`TMR_CTRL_ENABLE] && (adj_count >= threshold_q);
   assign irq_level = condition_reached && !ctrl_q[`TMR_CTRL_IMASK];

endmodule

/* File: core/tmr_timer_core.sv */
// Timer views top: access decode, channel array, readback and interrupt lines.
// Assumes sys_count is a free-running count on clk and the access port is
// driven by processor logic on the same clock, one request per cycle at most.
`timescale 1ns/100ps
`include "tmr_defs.svh"

////////////////////////////////////////////////////////////////////////////////

// How it works
// - Each channel keeps a 64-bit threshold; condition is enable bit set and adjusted count >= threshold.
// - While the condition holds, the channel interrupt is raised unless masked.
// - Physical channels use zero offset; the virtual channel uses the offset register.
// - Virtual count reads as physical count minus offset, modulo 2^64.
// - Count, offset and threshold compare unsigned; near all-ones may never fire.
// - Countdown view acts as a signed 32-bit down-counter reaching zero at match.
// - Countdown read gives low 32 bits of threshold minus adjusted count.
// - Countdown write sets threshold to adjusted count plus sign-extended value.
// - Countdown values are two's complement, so the arithmetic is sign-aware.
// - After the match, countdown reads as minus the ticks elapsed since then.
// - Unallocated written field values have no functional effect.
module tmr_timer_core #(
   parameter int NUM_CH = 4,
   parameter int VIRT_CH = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`TMR_DATA_W-1:0] sys_count,
   input wire logic acc_valid,
   input wire tmr_pkg::tmr_req_t acc_req,
   output logic rsp_valid,
   output tmr_pkg::tmr_rsp_t acc_rsp,
   output logic [NUM_CH-1:0] irq,
   output logic [NUM_CH-1:0] cond_met,
   output logic [NUM_CH-1:0] cond_rise
);

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.

   // The address map has two channel-select bits, so at most four channels.
   if (NUM_CH < 1 || NUM_CH > (1 << `TMR_CH_SEL_W)) begin : g_bad_num_ch
      $error("tmr_timer_core: NUM_CH must be 1 to 4");
   end
   if (VIRT_CH < 0 || VIRT_CH >= NUM_CH) begin : g_bad_virt_ch
      $error("tmr_timer_core: VIRT_CH must name an existing channel");
   end

   // The field macros must agree with one another, or the decode silently misroutes accesses.
   if (`TMR_CDV_W > `TMR_DATA_W) begin : g_bad_cdv_w
      $error("tmr_timer_core: countdown view wider than the data word");
   end
   if (`TMR_CTRL_STATUS < `TMR_CTRL_W) begin : g_bad_status_pos
      $error("tmr_timer_core: status bit overlaps the stored control bits");
   end
   if (`TMR_CTRL_ENABLE >= `TMR_CTRL_W || `TMR_CTRL_IMASK >= `TMR_CTRL_W) begin : g_bad_ctrl_pos
      $error("tmr_timer_core: enable and mask must sit in the stored control bits");
   end
   if (`TMR_CH_IDX_HI - `TMR_CH_IDX_LO + 1 != `TMR_CH_SEL_W) begin : g_bad_ch_field
      $error("tmr_timer_core: channel field width disagrees with the select width");
   end
   if (`TMR_KIND_HI - `TMR_KIND_LO + 1 != `TMR_KIND_W) begin : g_bad_kind_field
      $error("tmr_timer_core: kind field width disagrees with the kind width");
   end
   // Kind and channel fields must not overlap, or one write would hit two registers.
   if (`TMR_CH_IDX_LO <= `TMR_KIND_HI || `TMR_CH_SPACE_BIT <= `TMR_CH_IDX_HI) begin : g_bad_field_order
      $error("tmr_timer_core: address fields overlap");
   end
   if (`TMR_CH_SPACE_BIT >= `TMR_ADDR_W) begin : g_bad_space_bit
      $error("tmr_timer_core: channel space bit lies outside the address");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic kind_is_mapped(input logic [`TMR_KIND_W-1:0] kind);
      kind_is_mapped = (kind == `TMR_KIND_COMPARE) ||
                       (kind == `TMR_KIND_COUNTDOWN) ||
                       (kind == `TMR_KIND_CONTROL);
   endfunction

   function automatic logic [`TMR_DATA_W-1:0] ctrl_word(input logic [`TMR_CTRL_W-1:0] ctrl,
                                                         input logic status);
      logic [`TMR_DATA_W-1:0] w;
      w = '0;
      w[`TMR_CTRL_W-1:0] = ctrl;
      w[`TMR_CTRL_STATUS] = status;
      ctrl_word = w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Access decode.

   wire is_read = acc_valid && !acc_req.write;
   wire is_write = acc_valid && acc_req.write;
   wire in_ch_space = acc_req.addr[`TMR_CH_SPACE_BIT];
   wire [`TMR_CH_SEL_W-1:0] ch_sel = acc_req.addr[`TMR_CH_IDX_HI:`TMR_CH_IDX_LO];
   wire [`TMR_KIND_W-1:0] kind_sel = acc_req.addr[`TMR_KIND_HI:`TMR_KIND_LO];
   wire ch_exists = 32'(ch_sel) < NUM_CH;
   wire hit_pcount = !in_ch_space && (acc_req.addr == `TMR_ADDR_PHYS_COUNT);
   wire hit_vcount = !in_ch_space && (acc_req.addr == `TMR_ADDR_VIRT_COUNT);
   wire hit_voff = !in_ch_space && (acc_req.addr == `TMR_ADDR_VIRT_OFFSET);
   wire hit_ch = in_ch_space && ch_exists && kind_is_mapped(kind_sel);
   wire mapped = hit_pcount || hit_vcount || hit_voff || hit_ch;
   // The two count registers are read-only; writing them is refused.
   wire write_refused = is_write && (hit_pcount || hit_vcount);
   wire acc_err = acc_valid && (!mapped || write_refused);

   wire voff_wr = is_write && hit_voff;
   wire ch_wr = is_write && hit_ch;
   wire wr_cmp_any = ch_wr && (kind_sel == `TMR_KIND_COMPARE);
   wire wr_cdv_any = ch_wr && (kind_sel == `TMR_KIND_COUNTDOWN);
   wire wr_ctl_any = ch_wr && (kind_sel == `TMR_KIND_CONTROL);

   ////////////////////////////////////////////////////////////////////////////////
   // Counts and offset.

   logic [`TMR_DATA_W-1:0] phys_count;
   logic [`TMR_DATA_W-1:0] virt_count;
   logic [`TMR_DATA_W-1:0] voff_q;

   tmr_count_track u_count (
      .clk(clk),
      .rst_b(rst_b),
      .sys_count(sys_count),
      .offset_wr(voff_wr),
      .offset_wdata(acc_req.wdata),
      .phys_count(phys_count),
      .virt_count(virt_count),
      .offset_q(voff_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Channels.

   logic [`TMR_DATA_W-1:0] ch_thr [NUM_CH];
   logic [`TMR_CTRL_W-1:0] ch_ctrl [NUM_CH];
   logic [`TMR_CDV_W-1:0] ch_cdv [NUM_CH];
   logic [NUM_CH-1:0] ch_cond;
   logic [NUM_CH-1:0] ch_irq;

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      // Only the virtual channel sees the offset; the rest see the raw count.
      wire [`TMR_DATA_W-1:0] adj = (i == VIRT_CH) ? virt_count : phys_count;
      wire sel = (32'(ch_sel) == i);
      wire wr_cmp = wr_cmp_any && sel;
      wire wr_cdv = wr_cdv_any && sel;
      wire wr_ctl = wr_ctl_any && sel;

      tmr_channel u_ch (
         .clk(clk),
         .rst_b(rst_b),
         .adj_count(adj),
         .wr_compare(wr_cmp),
         .wr_countdown(wr_cdv),
         .wr_ctrl(wr_ctl),
         .wdata(acc_req.wdata),
         .threshold_q(ch_thr[i]),
         .ctrl_q(ch_ctrl[i]),
         .countdown_value(ch_cdv[i]),
         .condition_reached(ch_cond[i]),
         .irq_level(ch_irq[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Readback.

   // Reads see the stored state before any write in the same cycle lands.
   logic [`TMR_DATA_W-1:0] rdata_d;
   logic [`TMR_DATA_W-1:0] ch_rdata;

   always_comb begin
      ch_rdata = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (32'(ch_sel) == i) begin
            case (kind_sel)
               `TMR_KIND_COMPARE: begin
                  ch_rdata = ch_thr[i];
               end
               `TMR_KIND_COUNTDOWN: begin
                  ch_rdata = {{(`TMR_DATA_W-`TMR_CDV_W){1'b0}}, ch_cdv[i]};
               end
               `TMR_KIND_CONTROL: begin
                  ch_rdata = ctrl_word(ch_ctrl[i], ch_cond[i]);
               end
               default: begin
                  ch_rdata = '0;
               end
            endcase
         end
      end
   end

   always_comb begin
      rdata_d = '0;
      if (is_read && !acc_err) begin
         if (hit_pcount) begin
            rdata_d = phys_count;
         end else if (hit_vcount) begin
            rdata_d = virt_count;
         end else if (hit_voff) begin
            rdata_d = voff_q;
         end else begin
            rdata_d = ch_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   logic rsp_valid_q;
   tmr_pkg::tmr_rsp_t rsp_q;
   logic [NUM_CH-1:0] irq_q;
   logic [NUM_CH-1:0] cond_q;
   logic [NUM_CH-1:0] rise_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else begin
         rsp_valid_q <= acc_valid;
         rsp_q.err <= acc_err;
         rsp_q.rdata <= rdata_d;
      end
   end

   // Levels are sampled every cycle with no holding of their own.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q <= '0;
         cond_q <= '0;
         rise_q <= '0;
      end else begin
         irq_q <= ch_irq;
         cond_q <= ch_cond;
         rise_q <= ch_cond & ~cond_q;
      end
   end

   assign rsp_valid = rsp_valid_q;
   assign acc_rsp = rsp_q;
   assign irq = irq_q;
   assign cond_met = cond_q;
   assign cond_rise = rise_q;

endmodule

/* File: tb/tmr_timer_core_assertions.sv */
// Checker for the timer views top: access answers and condition lines.
// Assumes it is bound into every tmr_timer_core instance, sharing its clock.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_timer_core_chk #(
   parameter int NUM_CH = 4,
   parameter int VIRT_CH = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`TMR_DATA_W-1:0] sys_count,
   input wire logic acc_valid,
   input wire tmr_pkg::tmr_req_t acc_req,
   input wire logic rsp_valid,
   input wire tmr_pkg::tmr_rsp_t acc_rsp,
   input wire logic [NUM_CH-1:0] irq,
   input wire logic [NUM_CH-1:0] cond_met,
   input wire logic [NUM_CH-1:0] cond_rise
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic rd = acc_valid && !acc_req.write;
   wire logic ch_rd = rd && acc_req.addr[`TMR_CH_SPACE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   AST_RSP_ONE: assert property (acc_valid |=> rsp_valid)
      else $error("no response one cycle after a request");
   AST_RSP_ONLY: assert property (!acc_valid |=> !rsp_valid)
      else $error("response without a request");
   AST_WR_ZERO: assert property (acc_valid && acc_req.write |=> acc_rsp.rdata == '0)
      else $error("write answered with nonzero data");
   AST_CNT_RO: assert property (acc_valid && acc_req.write && acc_req.addr < 5'h02 |=> acc_rsp.err)
      else $error("write to a count register accepted");
   AST_PHYS_CNT: assert property (rd && acc_req.addr == 5'h00 |=> acc_rsp.rdata == $past(sys_count))
      else $error("physical count read differs from system count");
   AST_CDV_HI: assert property (ch_rd && acc_req.addr[1:0] == 2'h1 |=> acc_rsp.rdata[63:32] == 32'h0)
      else $error("countdown read has upper bits set");
   AST_CTRL_HI: assert property (ch_rd && acc_req.addr[1:0] == 2'h2 |=> acc_rsp.rdata[63:3] == '0)
      else $error("control read has undefined bits set");
   AST_UNMAPPED: assert property (acc_valid && !acc_req.addr[4] && acc_req.addr > 5'h02 |=>
      acc_rsp.err && acc_rsp.rdata == '0)
      else $error("unmapped access not refused");
   AST_IRQ_COND: assert property ((irq & ~cond_met) == '0)
      else $error("interrupt raised without condition");
   AST_RISE: assert property (cond_rise == (cond_met & ~$past(cond_met)))
      else $error("condition rise pulse misplaced");
endmodule

bind tmr_timer_core tmr_timer_core_chk #(.NUM_CH(NUM_CH), .VIRT_CH(VIRT_CH)) u_chk (
   .clk(clk), .rst_b(rst_b), .sys_count(sys_count), .acc_valid(acc_valid), .acc_req(acc_req),
   .rsp_valid(rsp_valid), .acc_rsp(acc_rsp), .irq(irq), .cond_met(cond_met), .cond_rise(cond_rise));

/* File: tb/tmr_timer_core_tb.sv */
// Self-checking bench for the timer views top with a behavioural model.
// Assumes the checker file binds its assertions into the design.
`timescale 1ns/100ps
`include "tmr_defs.svh"

module tmr_timer_core_tb;
   localparam int VC = 3;
   logic clk, rst_b, acc_valid, rsp_valid;
   logic [`TMR_DATA_W-1:0] sys_count, off, rnd;
   tmr_pkg::tmr_req_t acc_req;
   tmr_pkg::tmr_rsp_t acc_rsp;
   logic [3:0] irq, cond_met, cond_rise, ec, ei, pe;
   logic [63:0] thr [4];
   logic [1:0] ctl [4];
   int mismatches, comparisons;

   tmr_timer_core #(.NUM_CH(4), .VIRT_CH(VC)) dut (.clk(clk), .rst_b(rst_b), .sys_count(sys_count),
      .acc_valid(acc_valid), .acc_req(acc_req), .rsp_valid(rsp_valid), .acc_rsp(acc_rsp), .irq(irq),
      .cond_met(cond_met), .cond_rise(cond_rise));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      #1 sys_count = sys_count + 64'h1;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   function automatic logic [63:0] adj(int c, logic [63:0] s);
      return (c == VC) ? s - off : s;
   endfunction

   function automatic logic met(int c, logic [63:0] s);
      return ctl[c][0] && (adj(c, s) >= thr[c]);
   endfunction

   // The model is sampled at the edge, before the access task updates it one step later.
   always @(posedge clk) begin
      if (rst_b === 1'b1) begin
         pe = ec;
         for (int c = 0; c < 4; c++) begin
            ec[c] = met(c, sys_count);
            ei[c] = ec[c] && !ctl[c][1];
         end
         #2;
         check(64'(cond_met), 64'(ec));
         check(64'(irq), 64'(ei));
         check(64'(cond_rise), 64'(ec & ~pe));
      end
   end

   task automatic acc(input logic w, input logic [4:0] a, input logic [63:0] d);
      logic [63:0] s, t, er;
      logic bad;
      int c;
      c = int'(a[3:2]);
      acc_valid = 1'b1;
      acc_req = '{write: w, addr: a, wdata: d};
      @(posedge clk);
      s = sys_count;
      #1;
      bad = a[4] ? (a[1:0] == 2'h3) : (a > 5'h02 || (w && a < 5'h02));
      t = thr[c] - adj(c, s);
      er = '0;
      if (!bad && !w) begin
         if (a == 5'h00) er = s;
         else if (a == 5'h01) er = s - off;
         else if (a == 5'h02) er = off;
         else if (a[1:0] == 2'h0) er = thr[c];
         else if (a[1:0] == 2'h1) er = {32'h0, t[31:0]};
         else er = {61'h0, met(c, s), ctl[c]};
      end
      check(64'(rsp_valid), 64'h1);
      check(64'(acc_rsp.err), 64'(bad));
      check(acc_rsp.rdata, er);
      if (w && !bad) begin
         if (a == 5'h02) off = d;
         else if (a[1:0] == 2'h0) thr[c] = d;
         else if (a[1:0] == 2'h1) thr[c] = adj(c, s) + {{32{d[31]}}, d[31:0]};
         else ctl[c] = d[1:0];
      end
   endtask

   task automatic idle(int n);
      acc_valid = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      acc_valid = 1'b0;
      acc_req = '0;
      off = '0;
      ec = '0;
      mismatches = 0;
      comparisons = 0;
      for (int c = 0; c < 4; c++) begin
         thr[c] = '0;
         ctl[c] = '0;
      end
      void'($urandom(32'h52a89151));
      sys_count = {$urandom, $urandom};
      repeat (16) @(posedge clk);
      #1;
      rst_b = 1'b1;
      for (int c = 0; c < 4; c++) begin
         for (int k = 0; k < 3; k++) acc(1'b0, 5'(16 + 4 * c + k), '0);
      end
      acc(1'b1, 5'h00, '1);
      acc(1'b1, 5'h01, '1);
      acc(1'b0, 5'h03, '0);
      acc(1'b1, 5'h13, '1);
      acc(1'b1, 5'h02, {$urandom, $urandom});
      acc(1'b0, 5'h01, '0);
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, 5'(18 + 4 * c), 64'hffff_0000_0000_fff1);
         acc(1'b1, 5'(17 + 4 * c), 64'h5);
         idle(9);
         acc(1'b0, 5'(17 + 4 * c), '0);
         acc(1'b0, 5'(16 + 4 * c), '0);
         acc(1'b1, 5'(18 + 4 * c), 64'h3);
         acc(1'b1, 5'(17 + 4 * c), 64'h0000_0000_8000_0000);
         acc(1'b1, 5'(16 + 4 * c), '1);
         idle(3);
      end
      // Data lands near the running count or near zero so conditions toggle often.
      for (int i = 0; i < 600; i++) begin
         rnd = (($urandom_range(0, 1) == 1) ? sys_count : 64'h0) + 64'($urandom_range(0, 40)) - 64'd20;
         acc(1'($urandom), 5'($urandom_range(0, 31)), rnd);
      end
      idle(2);
      tally_and_finish();
   end
endmodule
